// ---- src/asr_ctrl.sv ----
// Host-side controller driving a 512K x 8 asynchronous static memory
//------------------------------------------------------------------
// Behaviour
// [RQ1] Wait power-up interval before first access
// [RQ2] Power-up wait at least one microsecond
// [RQ3] 19-bit address, one byte per access
// [RQ4] Write lasts while select and strobe low
// [RQ5] Write ends when either strobe rises
// [RQ6] Data held around terminating strobe edge
// [RQ7] Write cycle covers float delay plus setup
// [RQ8] Deselected device floats bus, enters standby
// [RQ9] Select, output enable low reads byte
// [RQ10] Select and strobe low write data
// [RQ11] Selected without enables keeps bus floating
// [RQ12] Output enable high during write, no drive
// [RQ13] Simultaneous release keeps outputs floating
// [RQ14] Write strobe high during whole read
// [RQ15] Address valid before select falls
// [RQ16] Host never drives while memory drives
// [RQ17] Retention only while deselected
// [RQ18] Wait one read cycle after retention
//------------------------------------------------------------------
`timescale 1ns/1ps
module asr_ctrl
    import asr_pkg::*;
#(
    parameter int PWR_CYC = POWER_UP_CYC
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // User request
    input  wire logic              req_valid,
    input  wire asr_req_t          req,
    output logic                   req_ready,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_data,
    // Retention control
    input  wire logic              retain_req,
    output logic                   retain_ok,
    // Memory pins
    output asr_pins_t              pins,
    input  wire logic [DATA_W-1:0] data_bus_i,
    output logic [DATA_W-1:0]      data_bus_o,
    output logic                   data_bus_oe
);
    typedef enum logic [2:0] {
        S_PWR, S_IDLE, S_RSETUP, S_READ, S_WSETUP, S_WRITE, S_WEND, S_RETAIN
    } asr_state_t;

    asr_state_t          state;
    asr_state_t          next_state;
    logic [15:0]         cnt;
    logic [15:0]         next_cnt;
    asr_pins_t           next_pins;
    logic [DATA_W-1:0]   next_data_o;
    logic                next_oe;
    logic                next_ready;
    logic                next_rd_valid;
    logic [DATA_W-1:0]   next_rd_data;
    logic                next_retain_ok;
    logic [DATA_W-1:0]   sync_data;

    asr_sync #(.W(DATA_W)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (data_bus_i),
        .q     (sync_data)
    );

    //--------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------
    // Reads wait four extra cycles for the three synchroniser stages and output register before capture
    localparam logic [15:0] RD_WAIT = 16'(READ_CYC + 4);
    always_comb begin
        next_state     = state;
        next_cnt       = (cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
        next_pins      = pins;
        next_data_o    = data_bus_o;
        next_oe        = data_bus_oe;
        next_ready     = 1'b0;
        next_rd_valid  = 1'b0;
        next_rd_data   = rd_data;
        next_retain_ok = 1'b0;
        unique case (state)
            // [RQ1] power-up hold
            S_PWR: begin
                if (cnt == 16'h0000) begin
                    next_state = S_IDLE;
                    next_ready = 1'b1;
                end
            end
            S_IDLE: begin
                next_ready = 1'b1;
                if (retain_req) begin
                    // [RQ17] stay deselected
                    next_state     = S_RETAIN;
                    next_ready     = 1'b0;
                    next_retain_ok = 1'b1;
                    next_pins      = PINS_IDLE;
                end else if (req_valid && req_ready) begin
                    next_ready = 1'b0;
                    // [RQ15] address before select
                    next_pins.address_bus = req.addr;
                    if (req.write) begin
                        next_state  = S_WSETUP;
                        next_data_o = req.wdata;
                    end else begin
                        next_state = S_RSETUP;
                    end
                end
            end
            S_RSETUP: begin
                // [RQ14] strobe stays high
                next_pins.chip_sel_n = 1'b0;
                next_pins.out_en_n   = 1'b0;
                next_pins.write_n    = 1'b1;
                next_cnt             = RD_WAIT;
                next_state           = S_READ;
            end
            S_READ: begin
                if (cnt == 16'h0000) begin
                    next_rd_data  = sync_data;
                    next_rd_valid = 1'b1;
                    next_pins     = PINS_IDLE;
                    next_pins.address_bus = pins.address_bus;
                    next_state    = S_IDLE;
                    next_ready    = 1'b1;
                end
            end
            S_WSETUP: begin
                // [RQ12] output enable high, no float wait
                next_pins.out_en_n   = 1'b1;
                next_pins.chip_sel_n = 1'b0;
                next_pins.write_n    = 1'b0;
                // [RQ16] drive only with memory outputs off
                next_oe              = 1'b1;
                next_cnt             = 16'(WRITE_CYC);
                next_state           = S_WRITE;
            end
            S_WRITE: begin
                // [RQ7] strobe width covers setup
                if (cnt == 16'h0001) begin
                    // [RQ5] strobe rise ends write
                    next_pins.write_n = 1'b1;
                    next_state        = S_WEND;
                end
            end
            S_WEND: begin
                // [RQ6] data and address held past rise
                next_pins.chip_sel_n = 1'b1;
                next_oe              = 1'b0;
                next_state           = S_IDLE;
                next_ready           = 1'b1;
            end
            S_RETAIN: begin
                next_retain_ok = retain_req;
                if (!retain_req && !retain_ok) begin
                    if (cnt == 16'h0000) begin
                        next_state = S_IDLE;
                        next_ready = 1'b1;
                    end
                end else begin
                    // [RQ18] recovery count restarts
                    next_cnt = 16'(RECOVERY_CYC);
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= S_PWR;
            // [RQ2] one microsecond count
            cnt         <= 16'(PWR_CYC);
            pins        <= PINS_IDLE;
            data_bus_o  <= '0;
            data_bus_oe <= 1'b0;
            req_ready   <= 1'b0;
            rd_valid    <= 1'b0;
            rd_data     <= '0;
            retain_ok   <= 1'b0;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            pins        <= next_pins;
            data_bus_o  <= next_data_o;
            data_bus_oe <= next_oe;
            req_ready   <= next_ready;
            rd_valid    <= next_rd_valid;
            rd_data     <= next_rd_data;
            retain_ok   <= next_retain_ok;
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_strobe_fall;
        $fell(pins.write_n);
    endsequence
    sequence s_strobe_low_span;
        (!pins.write_n && !pins.chip_sel_n) [*1];
    endsequence

    property p_no_contend;
        data_bus_oe |-> pins.out_en_n;
    endproperty
    a_no_contend: assert property (p_no_contend) // [RQ16]
        else $error("host drives bus with memory outputs on");

    property p_read_we_high;
        !pins.out_en_n |-> pins.write_n;
    endproperty
    a_read_we_high: assert property (p_read_we_high) // [RQ14]
        else $error("write strobe low during read");

    property p_addr_stable;
        (!pins.chip_sel_n && !$past(pins.chip_sel_n)) |-> $stable(pins.address_bus);
    endproperty
    a_addr_stable: assert property (p_addr_stable) // [RQ15]
        else $error("address moved while selected");

    property p_write_width;
        s_strobe_fall |-> s_strobe_low_span ##1 (pins.write_n && !pins.chip_sel_n);
    endproperty
    a_write_width: assert property (p_write_width) // [RQ7]
        else $error("write strobe width wrong");

    property p_data_hold;
        $rose(pins.write_n) && data_bus_oe |->
            $stable(data_bus_o) && $stable(pins.address_bus) && data_bus_oe;
    endproperty
    a_data_hold: assert property (p_data_hold) // [RQ6]
        else $error("write data not held at strobe rise");

    property p_cs_after_we;
        $rose(pins.write_n) && data_bus_oe |=> $rose(pins.chip_sel_n);
    endproperty
    a_cs_after_we: assert property (p_cs_after_we) // [RQ5]
        else $error("select not released after write");

    property p_retain_desel;
        retain_ok |-> pins.chip_sel_n;
    endproperty
    a_retain_desel: assert property (p_retain_desel) // [RQ17]
        else $error("selected during retention");

    property p_pwr_quiet;
        state == S_PWR |-> pins.chip_sel_n && !req_ready;
    endproperty
    a_pwr_quiet: assert property (p_pwr_quiet) // [RQ1]
        else $error("access during power-up wait");

    property p_recover;
        $fell(retain_ok) |-> !req_ready [*2];
    endproperty
    a_recover: assert property (p_recover) // [RQ18]
        else $error("access too soon after retention");
endmodule

// ---- src/asr_pkg.sv ----
// Package for the asynchronous static memory port controller
package asr_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // ------------------------------------------------------------
    // Timing (ns) and derived cycle counts at 50 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS          = 20;
    localparam int POWER_UP_WAIT_NS       = 1000;
    localparam int READ_CYCLE_TIME_NS     = 20;
    localparam int WRITE_FLOAT_DELAY_NS   = 8;
    localparam int WRITE_DATA_SETUP_NS    = 9;
    localparam int RETENTION_RECOVERY_NS  = READ_CYCLE_TIME_NS;
    localparam int POWER_UP_CYC =
        (POWER_UP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC =
        (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC =
        (WRITE_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC =
        (RETENTION_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asr_req_t;
    typedef struct packed {
        logic              chip_sel_n;
        logic              out_en_n;
        logic              write_n;
        logic [ADDR_W-1:0] address_bus;
    } asr_pins_t;
    localparam asr_pins_t PINS_IDLE = '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
                                        address_bus: '0};
endpackage

// ---- src/asr_sync.sv ----
// Three-stage input synchroniser for the returning data bus
`timescale 1ns/1ps
module asr_sync
    import asr_pkg::*;
#(
    parameter int W = DATA_W
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;
    // Value counts only once the last two stages agree
    always_comb begin
        next_q = (s2 == s3) ? s3 : q;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule

// ---- test/asr_ctrl_tb.sv ----
// Self-checking testbench of the static memory port controller
`timescale 1ns/1ps
module asr_ctrl_tb;
    import asr_pkg::*;
    localparam int PWR = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    asr_req_t req = '0;
    logic retain_req = 1'b0;
    logic req_ready, rd_valid, retain_ok, data_bus_oe, viol;
    logic [DATA_W-1:0] rd_data, data_bus_i, data_bus_o;
    asr_pins_t pins;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [ADDR_W-1:0] adr [4] = '{19'h00000, 19'h00001, 19'h7FFFF, 19'h2AAAA};
    logic [DATA_W-1:0] dat [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
    asr_ctrl #(.PWR_CYC(PWR)) dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .retain_req(retain_req), .retain_ok(retain_ok), .pins(pins),
        .data_bus_i(data_bus_i), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe));
    asr_mem_model #(.PWR_CYC(PWR)) mem (.mclk(mclk), .rst_n(rst_n), .pins(pins),
        .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe), .retain_ok(retain_ok),
        .data_bus_i(data_bus_i), .viol(viol));
    always #10 mclk = ~mclk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    // Hold the request until the edge where ready is seen high
    task automatic do_req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= '{write: w, addr: a, wdata: d};
        @(negedge mclk);
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask
    task automatic t_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        do_req(1'b1, a, d);
        repeat (2) @(negedge mclk);
        // Write mode with output enable high
        check("write_pins", {pins.chip_sel_n, pins.write_n, pins.out_en_n, data_bus_oe}, 4'h3);
        check("write_addr", pins.address_bus, a);
        @(negedge mclk);
        // Strobe ends write, select and data still held
        check("write_end", {pins.chip_sel_n, pins.write_n, data_bus_oe}, 3'h3);
    endtask
    task automatic t_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        do_req(1'b0, a, 8'h00);
        while (rd_valid !== 1'b1 && n < 30) begin
            @(negedge mclk);
            n++;
        end
        check("read_data", rd_data, exp);
    endtask
    task automatic t_power();
        int n;
        n = 0;
        // Pins stay idle while reset is held
        check("reset_pins", {pins, data_bus_oe, req_ready}, {PINS_IDLE, 2'b00});
        @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        check("power_wait", n >= PWR, 1'b1);
    endtask
    task automatic t_retain();
        int n;
        n = 0;
        @(posedge mclk);
        retain_req <= 1'b1;
        repeat (3) @(negedge mclk);
        check("retain_ok", {retain_ok, pins.chip_sel_n}, 2'b11);
        @(posedge mclk);
        retain_req <= 1'b0;
        @(negedge mclk);
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        check("recovery", n >= RECOVERY_CYC, 1'b1);
        check("idle_after", pins.chip_sel_n, 1'b1);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        t_power();
        for (int i = 0; i < 4; i++) t_write(adr[i], dat[i]);
        for (int i = 0; i < 4; i++) t_read(adr[i], dat[i]);
        // Overwrite then read straight back
        t_write(adr[1], 8'h81);
        t_read(adr[1], 8'h81);
        t_retain();
        t_read(adr[2], dat[2]);
        check("host_misuse", viol, 1'b0);
        print_verdict();
    end
endmodule

// ---- test/asr_mem_model.sv ----
// Behavioural model of the 512K x 8 asynchronous static memory
`timescale 1ns/1ps
module asr_mem_model
    import asr_pkg::*;
#(
    parameter int PWR_CYC = 4
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Memory pins
    input  wire asr_pins_t         pins,
    input  wire logic [DATA_W-1:0] data_bus_o,
    input  wire logic              data_bus_oe,
    input  wire logic              retain_ok,
    output logic [DATA_W-1:0]      data_bus_i,
    // Sticky flag for host misbehaviour
    output logic                   viol
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] wdat;
    logic [ADDR_W-1:0] wadr;
    logic [ADDR_W-1:0] prev_adr;
    logic [DATA_W-1:0] flt = 8'h96;
    logic              drv;
    logic              wr_live;
    logic              prev_sel;
    int                up_cnt;
    assign drv = !pins.chip_sel_n && !pins.out_en_n && pins.write_n;
    assign wr_live = !pins.chip_sel_n && !pins.write_n;
    // Undriven bus flips each cycle, so a stale value never reads as good
    always @(posedge mclk) flt <= ~data_bus_i;
    always @* begin
        if (data_bus_oe)
            data_bus_i = data_bus_o;
        else if (drv)
            data_bus_i = mem.exists(pins.address_bus) ? mem[pins.address_bus] : 8'h3C;
        else
            data_bus_i = flt;
    end
    always @* begin
        if (wr_live) begin
            wdat = data_bus_o;
            wadr = pins.address_bus;
        end
    end
    // Either strobe rising closes the write
    always @(negedge wr_live) mem[wadr] = wdat;
    // Host-side rules observed on the pins
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            viol     <= 1'b0;
            up_cnt   <= 0;
            prev_sel <= 1'b0;
            prev_adr <= '0;
        end else begin
            up_cnt   <= up_cnt + 1;
            prev_sel <= !pins.chip_sel_n;
            prev_adr <= pins.address_bus;
            viol <= viol | (data_bus_oe && drv) | (wr_live && !data_bus_oe)
                  | (!pins.chip_sel_n && up_cnt < PWR_CYC)
                  | (prev_sel && !pins.chip_sel_n && pins.address_bus != prev_adr)
                  | (retain_ok && !pins.chip_sel_n);
        end
    end
endmodule
